/* verilog/ocsp_top.sv */
// Module: overcurrent gate block, speed pulse, reverse flag and lead clip
`timescale 1ns/10ps
module ocsp_top #(
  parameter int CARRIER = ocsp_pkg::CARRIER_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Current sense comparator (high when sense above 0.5 V) and open detect
  input wire logic current_sense_input,
  input wire logic sense_open,
  // Hall sector 0..5 and rotation direction command
  input wire logic [2:0] hall_sector,
  input wire logic dir_ccw,
  // Speed pulse rate select (high or open gives 3 pulses)
  input wire logic pulse_rate_select,
  // Lead angle and limit, already digitised full scale
  input wire logic [ocsp_pkg::LEAD_W-1:0] lead_angle_input,
  input wire logic [ocsp_pkg::LEAD_W-1:0] lead_limit_input,
  // Commutation requests from the PWM generator
  input wire logic [5:0] phase_req,
  // Outputs
  output logic [5:0] phase_out,
  output logic [ocsp_pkg::LEAD_W-1:0] lead_code,
  output logic speed_pulse_out,
  output logic reverse_flag_out,
  output logic blocked
);
  import ocsp_pkg::*;
  // Trip walk: the sense input must stay high for the filter length before
  // the filtered level rises; the gates are cut on the following edge. The
  // block then stays until the filtered level has fallen and a full carrier
  // cycle has been counted after the last trip clock, so a motor that keeps
  // drawing too much current is never released in the middle of a fault.
  // An open sense pin cuts the gates without any filter delay and without
  // the carrier hold: the gates return one edge after the pin is driven again.
  // Limitation: the filter length is fixed by the package at the nominal
  // clock; a slower clock stretches it in proportion.
  // The speed pulse and reverse flag follow hall sector steps one edge late;
  // a jump over a sector leaves the reverse flag unchanged, since its sense is unknown.
  // Lead clipping is pure selection; the scale of the code (0 to 58 degrees
  // over the full code range) is set by the digitiser in front of this block.

  initial
  begin
    if (CARRIER < 2 || CARRIER > 65535)
      $error("carrier length out of range");
    if (LEAD_W < 1 || LEAD_W > 8)
      $error("lead code width out of range");
    if (FILT_CYC < 1 || FILT_CYC > 255)
      $error("filter length out of range");
  end

  // Successor of a hall sector, wrapping after the last one
  // Shared by both step senses so they can never disagree on the wrap
  function automatic logic [2:0] sector_after(input logic [2:0] s);
    if (s == SECTORS - 3'h1)
      return 3'h0;
    else
      return s + 3'h1;
  endfunction

  // Smaller of two lead codes; on a tie either value is the same
  // Kept as a function so the clip rule reads as one selection
  function automatic logic [LEAD_W-1:0] lead_min(input logic [LEAD_W-1:0] a,
    input logic [LEAD_W-1:0] b);
    if (a > b)
      return b;
    else
      return a;
  endfunction

  ocsp_filt_if fi ();
  assign fi.raw = current_sense_input;
  // Filtered comparator; short spikes from switching never reach the gates
  ocsp_filter #(.CYC(FILT_CYC)) u_filt (
    .clock(clock),
    .resetn(resetn),
    .f(fi)
  );

  // Block state: a trip holds outputs off until one full carrier cycle after it clears
  ocsp_state_t state;
  ocsp_state_t next_state;
  logic [15:0] ccount;

  wire trip = fi.level;
  wire carrier_done = (ccount == 16'(CARRIER - 1));

  // Next state: leave the block only when the filtered trip is gone
  always_comb
  begin
    next_state = state;
    unique case (state)
      OCSP_RUN:
      begin
        if (trip)
          next_state = OCSP_BLOCK;
      end
      OCSP_BLOCK:
      begin
        if (carrier_done && !trip)
          next_state = OCSP_RUN;
      end
      default: next_state = OCSP_RUN;
    endcase
  end

  // Carrier counter restarts on each trip so release needs a clean full cycle
  wire restart = (state == OCSP_RUN) || trip || carrier_done;
  wire [15:0] next_ccount = restart ? 16'h0000 : ccount + 16'h0001;
  always_ff @(posedge clock)
  begin
    if (!resetn)
      ccount <= 16'h0000;
    else
      ccount <= next_ccount;
  end

  // State register; reset comes out unblocked
  always_ff @(posedge clock)
  begin
    if (!resetn)
      state <= OCSP_RUN;
    else
      state <= next_state;
  end

  // Gate outputs: open sense pin is treated as a fault for as long as it stays open
  // It bypasses the filter, so a broken sense wire never lets the motor run
  wire held = (state == OCSP_BLOCK);
  wire gate_off = held || trip || sense_open;

  // Gate indication, registered alongside the phase outputs
  always_ff @(posedge clock)
  begin
    if (!resetn)
      blocked <= BLOCK_RST;
    else
      blocked <= gate_off;
  end

  // One gated flip-flop per commutation output; all six are cut on one edge
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_phase
      always_ff @(posedge clock)
      begin
        if (!resetn)
          phase_out[gi] <= 1'b0;
        else
          phase_out[gi] <= gate_off ? 1'b0 : phase_req[gi];
      end
    end
  endgenerate

  // Lead code: linear 0..31 maps 0 to 58 degrees; clip to limit
  wire [LEAD_W-1:0] clipped = lead_min(lead_angle_input, lead_limit_input);

  // Registered so the code seen downstream never glitches between inputs
  always_ff @(posedge clock)
  begin
    if (!resetn)
      lead_code <= 5'h00;
    else
      lead_code <= clipped;
  end

  // Sector tracking: last sector seen, to tell steps from noise
  logic [2:0] last_sector;
  wire [2:0] fwd_target = sector_after(last_sector);
  wire [2:0] back_target = sector_after(hall_sector);
  wire step_fwd = (hall_sector == fwd_target);
  wire step_back = (last_sector == back_target);
  wire moved = (hall_sector != last_sector);

  // Only an adjacent step updates the flag; a skipped sector says nothing
  wire adjacent = moved && (step_fwd || step_back);
  // Rotation sense opposite to command means reverse
  wire rev_seen = dir_ccw ? step_fwd : step_back;

  // 3 ppr toggles per sector, 1 ppr is high for sectors 0..2
  wire next_fg = pulse_rate_select ? hall_sector[0] : (hall_sector < 3'h3);

  // Sector history
  always_ff @(posedge clock)
  begin
    if (!resetn)
      last_sector <= 3'h0;
    else
      last_sector <= hall_sector;
  end

  // Speed pulse output
  always_ff @(posedge clock)
  begin
    if (!resetn)
      speed_pulse_out <= 1'b0;
    else
      speed_pulse_out <= next_fg;
  end

  // Reverse flag holds its level between steps
  always_ff @(posedge clock)
  begin
    if (!resetn)
      reverse_flag_out <= 1'b0;
    else if (adjacent)
      reverse_flag_out <= rev_seen;
  end
endmodule

/* verilog/ocsp_pkg.sv */
// Package: constants and types for the overcurrent block and speed pulse logic
package ocsp_pkg;
  // Clock rate and digital filter time constant
  localparam int CLK_HZ = 25000000;
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * (CLK_HZ / 1000000)) / 1000;
  // Carrier cycle length in clocks (oscillator divided by 252)
  localparam int CARRIER_CYC = 252;
  // Lead angle code width and full-scale code
  localparam int LEAD_W = 5;
  localparam logic [4:0] LEAD_MAX = 5'h1F;
  // Hall sector count per electrical cycle
  localparam logic [2:0] SECTORS = 3'h6;
  // Reset value of the blocked output
  localparam logic BLOCK_RST = 1'b0;
  typedef enum logic [1:0] {OCSP_RUN, OCSP_BLOCK} ocsp_state_t;
endpackage

/* verilog/ocsp_filt_if.sv */
// Interface: filter output toward the protection logic
`timescale 1ns/10ps
interface ocsp_filt_if;
  logic raw;
  logic level;
  modport filt (input raw, output level);
  modport user (output raw, input level);
endinterface

/* verilog/ocsp_filter.sv */
// Module: digital hold-time filter for the current comparator
`timescale 1ns/10ps
module ocsp_filter #(
  parameter int CYC = ocsp_pkg::FILT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Filtered channel
  ocsp_filt_if.filt f
);
  import ocsp_pkg::*;
  initial
  begin
    if (CYC < 1 || CYC > 255)
      $error("filter length out of range");
  end
  logic [7:0] count;
  logic level;
  wire agree = (f.raw == level);
  wire done = (count == 8'(CYC - 1));
  // Output changes only after input held the other level for CYC clocks
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      count <= 8'h00;
      level <= 1'b0;
    end
    else if (agree)
      count <= 8'h00;
    else if (done)
    begin
      count <= 8'h00;
      level <= f.raw;
    end
    else
      count <= count + 8'h01;
  end
  assign f.level = level;
endmodule

/* sim/ocsp_monitor.sv */
// Checker for the gate block, filter, speed pulse and lead clip
`timescale 1ns/10ps
module ocsp_mon #(parameter int CARRIER = 8) (
  // Inputs and outputs of the top module
  input wire logic clock, resetn, current_sense_input, sense_open,
  input wire logic [2:0] hall_sector,
  input wire logic pulse_rate_select,
  input wire logic [4:0] lead_angle_input, lead_limit_input,
  input wire logic [5:0] phase_req, phase_out,
  input wire logic [4:0] lead_code,
  input wire logic speed_pulse_out, blocked
);
  int hc, lc;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // Run lengths of the raw comparator, cleared in reset like the filter
  always_ff @(posedge clock)
  begin
    hc <= (resetn && current_sense_input) ? hc + 1 : 0;
    lc <= (resetn && !current_sense_input) ? lc + 1 : 0;
  end
  blk_gates_a: assert property (blocked |-> phase_out == 6'h00) else $error("gate leak");
  trip_late_a: assert property (hc == 27 |-> blocked) else $error("no trip");
  filt_hold_a: assert property ($rose(current_sense_input) && !blocked |=> !blocked [*8])
    else $error("trip unfiltered");
  blk_min_a: assert property ($rose(blocked) && !$past(sense_open) |-> blocked [*8])
    else $error("short block");
  blk_lift_a: assert property (lc == CARRIER + 32 && !sense_open && !$past(sense_open) |-> !blocked)
    else $error("block stuck");
  open_off_a: assert property (sense_open |=> phase_out == 6'h00) else $error("open leak");
  fg_rate_a: assert property ($past(resetn) |-> speed_pulse_out == ($past(pulse_rate_select) ?
    $past(hall_sector[0]) : $past(hall_sector) < 3'h3)) else $error("fg rate");
  lead_clip_a: assert property ($past(resetn) |-> lead_code == ($past(lead_angle_input) >
    $past(lead_limit_input) ? $past(lead_limit_input) : $past(lead_angle_input)))
    else $error("lead clip");
  rst_clear_a: assert property (disable iff (1'b0) !resetn |=> phase_out == 6'h00 && !blocked)
    else $error("reset state");
  cover property ($rose(blocked));
  cover property ($fell(blocked));
  cover property (sense_open);
endmodule
bind ocsp_top ocsp_mon #(.CARRIER(CARRIER)) mon_u (.*);

/* sim/ocsp_hall.sv */
// Rotor position model feeding the sector input
`timescale 1ns/10ps
module ocsp_hall (
  // Step commands and sector
  input wire logic clock,
  input wire logic fwd,
  input wire logic back,
  output logic [2:0] hall_sector
);
  initial hall_sector = 3'h0;
  // Adjacent steps only, wrapping over six sectors as a real rotor does
  always @(posedge clock)
  begin
    if (fwd) hall_sector <= (hall_sector == 3'h5) ? 3'h0 : hall_sector + 3'h1;
    else if (back) hall_sector <= (hall_sector == 3'h0) ? 3'h5 : hall_sector - 3'h1;
  end
endmodule

/* sim/testbench.sv */
// Bench for the gate block, speed pulse, reverse flag and lead clip
`timescale 1ns/10ps
module testbench;
  import ocsp_pkg::*;
  logic clock = 0, resetn = 0, cs = 0, so = 0, dir = 0, prs = 1, fw = 0, bk = 0, fg, rv, bl;
  logic [4:0] la = 5'h00, ll = 5'h1F, lc;
  logic [5:0] rq = 6'h15, po;
  logic [2:0] hs;
  int n_errors = 0, n_tests = 0, cyc = 0;
  ocsp_top #(.CARRIER(8)) dut_u (.clock(clock), .resetn(resetn), .current_sense_input(cs),
    .sense_open(so), .hall_sector(hs), .dir_ccw(dir), .pulse_rate_select(prs),
    .lead_angle_input(la), .lead_limit_input(ll), .phase_req(rq), .phase_out(po),
    .lead_code(lc), .speed_pulse_out(fg), .reverse_flag_out(rv), .blocked(bl));
  ocsp_hall hall_u (.clock(clock), .fwd(fw), .back(bk), .hall_sector(hs));
  initial forever #20 clock = ~clock;
  // Hang guard, far above the fewer than two hundred cycles the tests need
  always @(posedge clock) if (++cyc > 5000) begin n_errors++; end_sim(); end
  task automatic chk(string nm, logic [5:0] seen, logic [5:0] exp);
    n_tests++;
    if (seen !== exp) begin n_errors++; $display("[ERR] %s exp %h seen %h", nm, exp, seen); end
  endtask
  task automatic end_sim();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cy(int n); repeat (n) @(negedge clock); endtask
  // A short glitch must pass, a long trip must block until a carrier after it clears
  task automatic t_trip();
    cs = 1; cy(10); cs = 0; cy(30); chk("glitch", {5'h00, bl}, 6'h00);
    cs = 1; cy(20); chk("early", po, rq);
    cy(8); chk("trip", po, 6'h00);
    cs = 0; cy(26); chk("hold", {5'h00, bl}, 6'h01);
    cy(14); chk("lift", po, rq);
    $display("done trip");
  endtask
  task automatic t_open();
    so = 1; cy(2); chk("open", po, 6'h00);
    so = 0; cy(2); chk("close", po, rq);
    $display("done open");
  endtask
  // Twelve forward steps span two electrical cycles
  task automatic t_fg(logic r, int e);
    int n = 0;
    logic p;
    prs = r; cy(2);
    repeat (12) begin p = fg; fw = 1; cy(1); fw = 0; cy(1); if (!p && fg) n++; end
    chk("fg", 6'(n), 6'(e));
    chk("fwd", {5'h00, rv}, 6'h00);
    $display("done fg");
  endtask
  task automatic t_rev();
    bk = 1; cy(1); bk = 0; cy(2); chk("rev", {5'h00, rv}, 6'h01);
    $display("done rev");
  endtask
  task automatic t_lead();
    logic [4:0] a[4] = '{5'h1F, 5'h05, 5'h1F, 5'h00};
    logic [4:0] l[4] = '{5'h10, 5'h10, 5'h1F, 5'h1F};
    logic [4:0] x[4] = '{5'h10, 5'h05, 5'h1F, 5'h00};
    for (int i = 0; i < 4; i++) begin
      la = a[i]; ll = l[i]; cy(2);
      chk("lead", {1'b0, lc}, {1'b0, x[i]});
    end
    $display("done lead");
  endtask
  initial begin
    cy(3); chk("rst", po, 6'h00);
    resetn = 1; cy(1); chk("unblk", {5'h00, bl}, 6'h00);
    t_trip(); t_open(); t_fg(1'b1, 6); t_fg(1'b0, 2); t_rev(); t_lead();
    end_sim();
  end
endmodule
